// file: hw/bcs_regs.vh
// Register offsets, fields, reset values and timing constants of the bypass sequencer
`ifndef BCS_REGS_VH
`define BCS_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define BCS_CTRL_OFS        12'h000
`define BCS_TIME_OFS        12'h004
`define BCS_INSEL_OFS       12'h008
`define BCS_STATUS_OFS      12'h00c

// ****************************************
// Control register fields
// ****************************************
`define BCS_CTRL_FAULT_EN   0
`define BCS_CTRL_FIRE_EN    1
`define BCS_CTRL_FIRE_LOGIC 2
`define BCS_CTRL_SPIN_START 3
`define BCS_CTRL_RST        4'h0

// ****************************************
// Input select fields (0 means unassigned)
// ****************************************
`define BCS_INSEL_FIRE_LSB  0
`define BCS_INSEL_TRIG_LSB  4
`define BCS_INSEL_W         4
`define BCS_INSEL_RST       8'h00

// ****************************************
// Changeover time, unit 100 ms
// ****************************************
`define BCS_TIME_RST        16'h0014
`define BCS_TICK_NS         100000000
`define BCS_CLK_NS          20
`define BCS_TICK_CYC        (`BCS_TICK_NS / `BCS_CLK_NS)

`endif

// file: hw/bcs_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module bcs_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Data
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // Output only changes when the second and third stage agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q     <= {W{1'b0}};
      s2_q     <= {W{1'b0}};
      s3_q     <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
    end
  end

endmodule
`default_nettype wire

// file: hw/bcs_timer.v
// Changeover dead-time timer: prescaler tick and down counter
`timescale 1ns/100ps
`default_nettype none

module bcs_timer #(
  parameter TICK_CYC = 5000000,
  parameter TW       = 16
) (
  // Clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // Control
  input  wire          start,
  input  wire [TW-1:0] load_val,
  output reg           done
);

  reg [31:0]   pre_q;
  reg [TW-1:0] cnt_q;
  reg          run_q;

  // Done pulses once when the programmed number of ticks has elapsed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 32'h0;
      cnt_q <= {TW{1'b0}};
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        pre_q <= 32'h0;
        cnt_q <= load_val;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == {TW{1'b0}}) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else if (pre_q == TICK_CYC - 1) begin
          pre_q <= 32'h0;
          cnt_q <= cnt_q - {{(TW-1){1'b0}}, 1'b1};
        end else begin
          pre_q <= pre_q + 32'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: hw/bcs_top.v
// Bypass contactor sequencer with APB register slave
`timescale 1ns/100ps
`default_nettype none
`include "bcs_regs.vh"

module bcs_top #(
  parameter NDI      = 8,
  parameter TICK_CYC = `BCS_TICK_CYC
) (
  // APB
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  // Drive inputs
  input  wire [NDI-1:0] din,
  input  wire          run_enable,
  input  wire          drive_trip,
  // Outputs
  output reg           relay_bypass,
  output reg           relay_drive,
  output reg           drive_output_en,
  output reg           bypass_active
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_DRIVE    = 3'd0;
  localparam [2:0] ST_TO_BYP   = 3'd1;
  localparam [2:0] ST_BYPASS   = 3'd2;
  localparam [2:0] ST_TO_DRV   = 3'd3;
  localparam [2:0] ST_OFF      = 3'd4;
  localparam [2:0] ST_OFF_WAIT = 3'd5;

  localparam [1:0] SRC_NONE  = 2'd0;
  localparam [1:0] SRC_FAULT = 2'd1;
  localparam [1:0] SRC_FIRE  = 2'd2;
  localparam [1:0] SRC_TRIG  = 2'd3;

  // Selects digital input by number; zero or out of range reads low, but only zero counts as unassigned
  function sel_in;
    input [NDI-1:0]       v;
    input [`BCS_INSEL_W-1:0] s;
    integer i;
    begin
      sel_in = 1'b0;
      for (i = 1; i <= NDI; i = i + 1) begin
        if (s == i[`BCS_INSEL_W-1:0]) begin
          sel_in = v[i-1];
        end
      end
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg  [3:0]  ctrl_q;
  reg  [15:0] time_q;
  reg  [7:0]  insel_q;
  reg  [2:0]  st_q;
  reg  [2:0]  st_d;
  reg  [1:0]  src_q;
  reg  [1:0]  src_d;
  reg         tmr_start;
  reg         byp_seen_q;

  wire [NDI+1:0] sync_v;
  wire           tmr_done;

  bcs_sync #(
    .W(NDI + 2)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .async_in({drive_trip, run_enable, din}),
    .sync_out(sync_v)
  );

  bcs_timer #(
    .TICK_CYC(TICK_CYC),
    .TW      (16)
  ) u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tmr_start),
    .load_val(time_q),
    .done    (tmr_done)
  );

  wire [`BCS_INSEL_W-1:0] fire_sel = insel_q[`BCS_INSEL_FIRE_LSB +: `BCS_INSEL_W];
  wire [`BCS_INSEL_W-1:0] trig_sel = insel_q[`BCS_INSEL_TRIG_LSB +: `BCS_INSEL_W];
  wire en_s   = sync_v[NDI];
  wire trip_s = sync_v[NDI+1];
  wire fire_raw = sel_in(sync_v[NDI-1:0], fire_sel);

  wire fire_act = ctrl_q[`BCS_CTRL_FIRE_LOGIC] ? fire_raw : ~fire_raw;
  wire fault_c = ctrl_q[`BCS_CTRL_FAULT_EN] & trip_s;
  wire fire_c  = ctrl_q[`BCS_CTRL_FIRE_EN] & (fire_sel != 4'h0) & fire_act;
  wire trig_c  = (trig_sel != 4'h0) & sel_in(sync_v[NDI-1:0], trig_sel);

  // After a fault release go to idle-off until re-enable, else to drive
  function [2:0] off_hold;
    input [1:0] s;
    begin
      off_hold = (s == SRC_FAULT) ? ST_OFF : ST_DRIVE;
    end
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    st_d      = st_q;
    src_d     = src_q;
    tmr_start = 1'b0;
    case (st_q)
      ST_DRIVE: begin
        // any source acts, trigger only with run enable; fire has priority
        if (fire_c) begin
          st_d = ST_TO_BYP;
          src_d = SRC_FIRE;
          tmr_start = 1'b1;
        end else if (trig_c && en_s) begin
          st_d = ST_TO_BYP;
          src_d = SRC_TRIG;
          tmr_start = 1'b1;
        end else if (fault_c) begin
          st_d = ST_TO_BYP;
          src_d = SRC_FAULT;
          tmr_start = 1'b1;
        end else if (!en_s && trig_sel != 4'h0) begin
          st_d = ST_OFF;
          src_d = SRC_NONE;
        end
      end
      ST_TO_BYP: begin
        if (tmr_done) begin
          st_d = ST_BYPASS;
        end
      end
      ST_BYPASS: begin
        case (src_q)
          SRC_FAULT: if (!en_s) begin
            st_d = ST_OFF_WAIT;
            tmr_start = 1'b1;
          end
          SRC_FIRE: if (!fire_c) begin
            st_d = ST_TO_DRV;
            tmr_start = 1'b1;
          end
          SRC_TRIG: if (fire_c) begin
            src_d = SRC_FIRE;
          end else if (!en_s) begin
            st_d = ST_OFF;
          end else if (!trig_c) begin
            st_d = ST_TO_DRV;
            tmr_start = 1'b1;
          end
          // Unknown source: fall back to drive through a full dead time
          default: begin
            st_d = ST_TO_DRV;
            tmr_start = 1'b1;
          end
        endcase
      end
      ST_TO_DRV: begin
        if (tmr_done) begin
          st_d = ST_DRIVE;
          src_d = SRC_NONE;
        end
      end
      ST_OFF: begin
        if (fire_c) begin
          st_d = ST_TO_BYP;
          src_d = SRC_FIRE;
          tmr_start = 1'b1;
        end else if (en_s) begin
          st_d = ST_OFF_WAIT;
          src_d = trig_c ? SRC_TRIG : SRC_NONE;
          tmr_start = 1'b1;
        end
      end
      ST_OFF_WAIT: begin
        // Dead time before closing whichever contactor comes next
        if (tmr_done) begin
          st_d = (src_q == SRC_TRIG) ? ST_BYPASS : off_hold(src_q);
        end
      end
      default: begin
        st_d = ST_OFF;
        src_d = SRC_NONE;
      end
    endcase
  end

  // Reset lands in all-off state so no relay is on before dead time
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= ST_OFF;
      src_q <= SRC_NONE;
      byp_seen_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      src_q <= ((st_q == ST_OFF_WAIT) && tmr_done && (src_q == SRC_FAULT)) ? SRC_NONE : src_d;
      byp_seen_q <= (st_d == ST_BYPASS) | byp_seen_q & (st_d != ST_DRIVE);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_bypass    <= 1'b0;
      relay_drive     <= 1'b0;
      drive_output_en <= 1'b0;
      bypass_active   <= 1'b0;
    end else begin
      relay_bypass    <= (st_d == ST_BYPASS);
      relay_drive     <= (st_d == ST_DRIVE);
      // output off outside drive state; trip also
      drive_output_en <= (st_d == ST_DRIVE) & en_s & ~trip_s;
      // indication
      // Dead time on the way back into trigger bypass counts as bypass too
      bypass_active   <= (st_d == ST_TO_BYP) | (st_d == ST_BYPASS) |
                         ((st_d == ST_OFF_WAIT) & (src_d == SRC_TRIG));
    end
  end

  // ****************************************
  // APB slave, zero wait states
  // ****************************************
  wire wr = psel & penable & pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `BCS_CTRL_RST;
      time_q  <= `BCS_TIME_RST;
      insel_q <= `BCS_INSEL_RST;
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `BCS_STATUS_OFS);
      if (wr && pready) begin
        case (paddr)
          `BCS_CTRL_OFS:  ctrl_q  <= pwdata[3:0];
          `BCS_TIME_OFS:  time_q  <= pwdata[15:0];
          `BCS_INSEL_OFS: insel_q <= pwdata[7:0];
          default: ;
        endcase
      end
      if (psel && !penable) begin
        case (paddr)
          `BCS_CTRL_OFS:   prdata <= {28'h0, ctrl_q};
          `BCS_TIME_OFS:   prdata <= {16'h0, time_q};
          `BCS_INSEL_OFS:  prdata <= {24'h0, insel_q};
          `BCS_STATUS_OFS: prdata <= {23'h0, byp_seen_q, src_q, st_q, relay_drive,
                                      relay_bypass, bypass_active};
          default:         prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: testbench/bcs_coil.sv
// Contactor model: contacts follow the coil after a travel delay
`timescale 1ns/100ps
`default_nettype none

module bcs_coil #(
  parameter TRAVEL = 5
) (
  // Clock
  input  wire logic pclk,
  // Coil and contacts
  input  wire logic coil,
  output var  logic closed = 1'b0
);
  int n = 0;

  // Unknown coil drive is treated as released, the safe reading
  always @(posedge pclk) begin
    if ((coil === 1'b1) == closed)
      n <= 0;
    else if (n == TRAVEL - 1) begin
      closed <= (coil === 1'b1);
      n      <= 0;
    end else
      n <= n + 1;
  end
endmodule
`default_nettype wire

// file: testbench/bcs_top_chk.sv
// Assertion checker for the bypass contactor sequencer ports
`timescale 1ns/100ps
`default_nettype none

module bcs_top_chk #(
  parameter NDI      = 8,
  parameter TICK_CYC = 5000000
) (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Relays and status
  input wire logic        relay_bypass,
  input wire logic        relay_drive,
  input wire logic        drive_output_en,
  input wire logic        bypass_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_relays_exclusive: assert property (!(relay_bypass && relay_drive))
    else $error("both relays energised");
  a_gap_to_bypass: assert property ($fell(relay_drive) |=> !relay_bypass)
    else $error("no gap before bypass relay");
  a_gap_to_drive: assert property ($fell(relay_bypass) |=> !relay_drive)
    else $error("no gap before drive relay");
  a_bypass_entry: assert property ($rose(relay_bypass) |->
    $past(bypass_active, 2) && !$past(relay_drive, 2))
    else $error("bypass closed without dead time shown");
  a_bypass_shown: assert property (relay_bypass |-> bypass_active)
    else $error("bypass on but not indicated");
  a_output_gated: assert property (drive_output_en |-> relay_drive)
    else $error("output enabled without drive contactor");
  a_bypass_no_mod: assert property (relay_bypass |-> !drive_output_en)
    else $error("output enabled during bypass");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  a_apb_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_apb_error: assert property (pready |-> (pslverr == (paddr > 12'h00c)))
    else $error("slave error wrong for address");
endmodule

bind bcs_top bcs_top_chk #(.NDI(NDI), .TICK_CYC(TICK_CYC)) u_bcs_top_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .relay_bypass(relay_bypass),
  .relay_drive(relay_drive), .drive_output_en(drive_output_en),
  .bypass_active(bypass_active));
`default_nettype wire

// file: testbench/test_bypass_contactor_sequencer.sv
// Testbench for the bypass contactor sequencer
`timescale 1ns/100ps
`default_nettype none
`include "bcs_regs.vh"

module test_bypass_contactor_sequencer;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, r;
  logic [7:0]  din = 8'h00;
  logic        run_enable = 1'b0, drive_trip = 1'b0, e;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, relay_bypass, relay_drive, drive_output_en, bypass_active;
  wire logic   k_byp, k_drv;
  int          error_cnt = 0, n_tests = 0;

  always #10 pclk = ~pclk;

  bcs_top #(.NDI(8), .TICK_CYC(10)) u_bcs_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .din(din), .run_enable(run_enable), .drive_trip(drive_trip),
    .relay_bypass(relay_bypass), .relay_drive(relay_drive),
    .drive_output_en(drive_output_en), .bypass_active(bypass_active));
  bcs_coil u_bcs_coil_b (.pclk(pclk), .coil(relay_bypass), .closed(k_byp));
  bcs_coil u_bcs_coil_d (.pclk(pclk), .coil(relay_drive), .closed(k_drv));

  // ****
  // Tasks
  // ****
  task automatic end_sim;
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      end_sim;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  // Cycles until the chosen relay reaches v must fall within lo..hi
  task automatic wt(input logic sel, input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while ((sel ? relay_bypass : relay_drive) !== v && n <= hi) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  task automatic hold(input logic sel, input logic v, input int c);
    repeat (c) begin
      @(posedge pclk);
      chk({31'h0, sel ? relay_bypass : relay_drive}, {31'h0, v});
    end
  endtask

  // Both contactors closed at once would short the supply onto the drive
  always @(posedge pclk) if (k_byp & k_drv) chk(32'h1, 32'h0);

  // ****
  // Sequence
  // ****
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(`BCS_CTRL_OFS, 32'h0);
    chk({31'h0, e}, 32'h0);
    rd(`BCS_TIME_OFS, 32'h14);
    rd(`BCS_INSEL_OFS, 32'h0);
    rd(12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, `BCS_TIME_OFS, 32'h3);
    rd(`BCS_TIME_OFS, 32'h3);
    apb(1'b1, `BCS_CTRL_OFS, 32'h9);
    run_enable <= 1'b1;
    wt(0, 1, 28, 80);
    chk({31'h0, drive_output_en}, 32'h1);
    drive_trip <= 1'b1;
    wt(0, 0, 0, 8);
    wt(1, 1, 28, 80);
    apb(1'b0, `BCS_STATUS_OFS, 32'h0);
    chk(r & 32'h7, 32'h3);
    drive_trip <= 1'b0;
    hold(1, 1, 60);
    run_enable <= 1'b0;
    wt(1, 0, 0, 8);
    repeat (60) @(posedge pclk);
    run_enable <= 1'b1;
    wt(0, 1, 28, 80);
    apb(1'b1, `BCS_CTRL_OFS, 32'h8);
    drive_trip <= 1'b1;
    hold(1, 0, 80);
    drive_trip <= 1'b0;
    run_enable <= 1'b0;
    repeat (10) @(posedge pclk);
    run_enable <= 1'b1;
    wt(0, 1, 0, 200);
    apb(1'b1, `BCS_CTRL_OFS, 32'he);
    din[1:0] <= 2'b11;
    hold(1, 0, 60);
    din[1:0] <= 2'b00;
    repeat (4) @(posedge pclk);
    apb(1'b1, `BCS_INSEL_OFS, 32'h1);
    din[0] <= 1'b1;
    wt(0, 0, 0, 8);
    chk({31'h0, drive_output_en}, 32'h0);
    wt(1, 1, 28, 80);
    din[0] <= 1'b0;
    wt(1, 0, 0, 8);
    wt(0, 1, 28, 80);
    chk({31'h0, drive_output_en}, 32'h1);
    apb(1'b1, `BCS_CTRL_OFS, 32'h8);
    din[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b1, `BCS_CTRL_OFS, 32'ha);
    din[0] <= 1'b0;
    wt(1, 1, 28, 80);
    din[0] <= 1'b1;
    wt(0, 1, 28, 80);
    apb(1'b1, `BCS_CTRL_OFS, 32'hb);
    apb(1'b1, `BCS_INSEL_OFS, 32'h21);
    din[1] <= 1'b1;
    wt(1, 1, 28, 80);
    run_enable <= 1'b0;
    wt(1, 0, 0, 8);
    hold(0, 0, 40);
    run_enable <= 1'b1;
    wt(1, 1, 28, 80);
    din[1] <= 1'b0;
    wt(0, 1, 28, 80);
    chk({31'h0, drive_output_en}, 32'h1);
    run_enable <= 1'b0;
    wt(0, 0, 0, 8);
    chk({31'h0, drive_output_en}, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire
